// ===== bench/plm_core_model.sv
// Behavioural model of the endpoint core side: stream beats and credits.
// Assumes the bench calls its tasks; signals change at falling edges.
`timescale 1ns/1ps
module plm_core_model (
  input  wire logic        clk,
  output logic             tx_tvalid,
  output logic             tx_tready,
  output logic [7:0]       tx_tkeep,
  output logic             tx_mwr_payload,
  output logic             rx_tvalid,
  output logic             rx_tready,
  output logic [7:0]       rx_tkeep,
  output logic             rx_cpld_payload,
  output logic             link_up,
  output logic [11:0]      crd_cd,
  output logic [7:0]       crd_ch,
  output logic [11:0]      crd_npd,
  output logic [7:0]       crd_nph,
  output logic [11:0]      crd_pd
);
  ////////////////////////////////////////////////////////////////////////
  // Idle values at time zero
  initial begin
    {tx_tvalid, tx_tready, tx_mwr_payload} = 3'h0;
    {rx_tvalid, rx_tready, rx_cpld_payload} = 3'h0;
    {tx_tkeep, rx_tkeep} = 16'h0;
    link_up = 1'b0;
    {crd_cd, crd_ch, crd_npd, crd_nph, crd_pd} = 52'h0;
  end

  // One beat on either stream; off-beat lanes show a changing pattern
  task automatic beat(input logic rx, input logic [7:0] keep,
                      input logic qual, input logic rdy);
    @(negedge clk);
    tx_tvalid = ~rx;
    tx_tready = ~rx & rdy;
    tx_tkeep = rx ? ~tx_tkeep : keep;
    tx_mwr_payload = rx ? ~tx_mwr_payload : qual;
    rx_tvalid = rx;
    rx_tready = rx & rdy;
    rx_tkeep = rx ? keep : ~rx_tkeep;
    rx_cpld_payload = rx ? qual : ~rx_cpld_payload;
  endtask

  // Streams go quiet; qualifiers keep toggling
  task automatic idle();
    @(negedge clk);
    {tx_tvalid, rx_tvalid} = 2'h0;
    tx_tkeep = ~tx_tkeep;
    rx_tkeep = ~rx_tkeep;
    tx_mwr_payload = ~tx_mwr_payload;
    rx_cpld_payload = ~rx_cpld_payload;
  endtask

  // Link state and the five initial credit values
  task automatic link(input logic up, input logic [51:0] crd);
    @(negedge clk);
    link_up = up;
    {crd_cd, crd_ch, crd_npd, crd_nph, crd_pd} = crd;
  endtask
endmodule

// ===== bench/tb_pcie_link_perf_monitor.sv
// Testbench of the link performance monitor: reads through the read port.
// Assumes the core model drives streams and credits at falling edges.
`timescale 1ns/1ps
module tb_pcie_link_perf_monitor;
  import plm_pkg::*;
  localparam int unsigned SC = 64;
  localparam logic [51:0] CRD_A = {12'hABC, 8'hDE, 12'h123, 8'h45, 12'hFFF};
  logic              ref_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              rd_en   = 1'b0;
  logic [ADDR_W-1:0] addr    = 16'h0000;
  logic              rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic              txv, txr, txq, rxv, rxr, rxq, lnk;
  logic [7:0]        txk, rxk, cch, cnph;
  logic [11:0]       ccd, cnpd, cpd;
  int                bad_count  = 0;
  int                num_checks = 0;
  int                cyc        = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock and edge counter since reset release
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (reset_n) cyc <= cyc + 1;

  plm_top #(.SAMPLE_CYCLES(SC)) plm_top_inst (
    .REF_CLK(ref_clk), .RESET_N(reset_n),
    .TX_TVALID(txv), .TX_TREADY(txr), .TX_TKEEP(txk), .TX_MWR_PAYLOAD(txq),
    .RX_TVALID(rxv), .RX_TREADY(rxr), .RX_TKEEP(rxk), .RX_CPLD_PAYLOAD(rxq),
    .LINK_UP(lnk), .CPL_DATA_CREDIT_INIT(ccd), .CPL_HEADER_CREDIT_INIT(cch),
    .NONPOSTED_DATA_CREDIT_INIT(cnpd), .NONPOSTED_HEADER_CREDIT_INIT(cnph),
    .POSTED_DATA_CREDIT_INIT(cpd), .REG_RD_EN(rd_en), .REG_ADDR(addr),
    .REG_RD_VALID(rd_valid), .REG_RD_DATA(rd_data));

  plm_core_model plm_core_model_inst (
    .clk(ref_clk), .tx_tvalid(txv), .tx_tready(txr), .tx_tkeep(txk),
    .tx_mwr_payload(txq), .rx_tvalid(rxv), .rx_tready(rxr), .rx_tkeep(rxk),
    .rx_cpld_payload(rxq), .link_up(lnk), .crd_cd(ccd), .crd_ch(cch),
    .crd_npd(cnpd), .crd_nph(cnph), .crd_pd(cpd));

  ////////////////////////////////////////////////////////////////////////
  // Compare, read and timing helpers
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge ref_clk);
    rd_en = 1'b0;
    addr = ~a;
    chk($sformatf("valid %h", a), 32'h1, {31'h0, rd_valid});
    chk($sformatf("data %h", a), e, rd_data);
  endtask

  // Expected byte-count word: bytes in 4-byte units over the sample count
  function automatic logic [31:0] cw(input logic [31:0] b, input int s);
    return {b[31:2], 2'(s)};
  endfunction

  task automatic wait_to(input int n);
    while (cyc < n) @(posedge ref_clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #(50 * SC * 8);
    bad_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    logic [15:0] ofs [11];
    ofs = '{OFS_TX_BYTES, OFS_RX_BYTES, OFS_MWR_BYTES, OFS_CPL_BYTES,
            OFS_CRD_CD, OFS_CRD_CH, OFS_CRD_NPD, OFS_CRD_NPH, OFS_CRD_PD,
            16'h9030, 16'h9008};
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    foreach (ofs[i]) begin
      rd(ofs[i], RST_WORD);
    end
    plm_core_model_inst.link(1'b1, CRD_A);
    plm_core_model_inst.link(1'b1, ~CRD_A);
    plm_core_model_inst.link(1'b0, 52'h0);
    // Sample one: transmit 31 bytes, 27 payload; receive 18 bytes, 16 payload
    repeat (3) plm_core_model_inst.beat(1'b0, 8'hFF, 1'b1, 1'b1);
    plm_core_model_inst.beat(1'b0, 8'h0F, 1'b0, 1'b1);
    plm_core_model_inst.beat(1'b0, 8'hFF, 1'b1, 1'b0);
    plm_core_model_inst.beat(1'b0, 8'h07, 1'b1, 1'b1);
    repeat (2) plm_core_model_inst.beat(1'b1, 8'hFF, 1'b1, 1'b1);
    plm_core_model_inst.beat(1'b1, 8'h03, 1'b0, 1'b1);
    plm_core_model_inst.beat(1'b1, 8'hFF, 1'b1, 1'b0);
    plm_core_model_inst.idle();
    wait_to(SC + 10);
    rd(OFS_TX_BYTES, cw(31, 1));
    rd(OFS_RX_BYTES, cw(18, 1));
    rd(OFS_MWR_BYTES, cw(27, 1));
    rd(OFS_CPL_BYTES, cw(16, 1));
    rd(OFS_CRD_CD, {20'h0, CRD_A[51:40]});
    rd(OFS_CRD_CH, {24'h0, CRD_A[39:32]});
    rd(OFS_CRD_NPD, {20'h0, CRD_A[31:20]});
    rd(OFS_CRD_NPH, {24'h0, CRD_A[19:12]});
    rd(OFS_CRD_PD, {20'h0, CRD_A[11:0]});
    // Sample two: one receive payload beat only
    plm_core_model_inst.beat(1'b1, 8'hFF, 1'b1, 1'b1);
    plm_core_model_inst.idle();
    wait_to(2 * SC + 10);
    rd(OFS_TX_BYTES, cw(0, 2));
    rd(OFS_RX_BYTES, cw(8, 2));
    rd(OFS_CPL_BYTES, cw(8, 2));
    wait_to(4 * SC + 10);
    rd(OFS_MWR_BYTES, cw(0, 4));
    rd(OFS_CRD_CD, {20'h0, CRD_A[51:40]});
    print_verdict();
  end
endmodule

// ===== design/plm_acc.sv
// One byte accumulator of the performance monitor.
// Assumes a one-cycle sample tick from the parent and a byte-keep mask.
`timescale 1ns/1ps
module plm_acc #(
  parameter int unsigned KEEP_W = plm_pkg::KEEP_W,
  parameter int unsigned ACC_W  = plm_pkg::ACC_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              beat_ok,
  input  wire logic [KEEP_W-1:0] keep,
  input  wire logic              tick,
  output logic      [ACC_W-1:0]  run_ff,
  output logic      [ACC_W-1:0]  snap_ff
);
  import plm_pkg::*;

  logic [ACC_W-1:0] beat_bytes;
  logic [ACC_W-1:0] add_bytes;
  logic [ACC_W-1:0] nxt_run;
  logic [ACC_W-1:0] nxt_snap;

  ////////////////////////////////////////////////////////////////////////////
  // Count of enabled byte lanes in the beat
  always_comb begin
    beat_bytes = '0;
    for (int i = 0; i < KEEP_W; i++) begin
      beat_bytes = beat_bytes + ACC_W'(keep[i]);
    end
  end

  // Beat at the boundary opens the new sample instead of being lost
  assign add_bytes = beat_ok ? beat_bytes : '0;
  assign nxt_run   = tick ? add_bytes : run_ff + add_bytes;
  assign nxt_snap  = tick ? run_ff : snap_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Running total and last-sample copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff  <= '0;
      snap_ff <= '0;
    end else begin
      run_ff  <= nxt_run;
      snap_ff <= nxt_snap;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ACC_RESTART: assert property (tick |=>
      run_ff == $past(add_bytes))
    else $error("accumulator did not restart at sample boundary");

endmodule

// ===== design/plm_pkg.sv
// Package for the link performance monitor: offsets, widths, timing.
// Assumes a 20 MHz user clock from the endpoint core.
package plm_pkg;

  // Sampling interval and clock rate
  localparam int unsigned ONE_SECOND_NS = 1000000000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SAMPLE_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W       = 32;

  // Data path widths
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned KEEP_W  = 8;
  localparam int unsigned ACC_W   = 32;
  localparam int unsigned SCNT_W  = 2;
  localparam int unsigned CRD_D_W = 12;
  localparam int unsigned CRD_H_W = 8;

  // Field positions of a byte-count register
  localparam int unsigned CNT_LSB = 2;

  // Register offsets within the first base address region
  localparam logic [ADDR_W-1:0] OFS_TX_BYTES  = 16'h900C;
  localparam logic [ADDR_W-1:0] OFS_RX_BYTES  = 16'h9010;
  localparam logic [ADDR_W-1:0] OFS_MWR_BYTES = 16'h9014;
  localparam logic [ADDR_W-1:0] OFS_CPL_BYTES = 16'h9018;
  localparam logic [ADDR_W-1:0] OFS_CRD_CD    = 16'h901C;
  localparam logic [ADDR_W-1:0] OFS_CRD_CH    = 16'h9020;
  localparam logic [ADDR_W-1:0] OFS_CRD_NPD   = 16'h9024;
  localparam logic [ADDR_W-1:0] OFS_CRD_NPH   = 16'h9028;
  localparam logic [ADDR_W-1:0] OFS_CRD_PD    = 16'h902C;

  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

  // Credit capture state
  typedef enum logic [0:0] {
    CAP_WAIT = 1'b0,
    CAP_HELD = 1'b1
  } plm_cap_t;

endpackage

// ===== design/plm_top.sv
// Link performance monitor: byte counts per one-second sample and
// captured initial flow-control credits, read from the first BAR region.
// Assumes the endpoint target logic decodes BAR0 reads into the read port
// and that the core marks memory-write and completion payload beats.
//
// Function
// - Bits 1:0 of each byte-count register hold a wrapping sample count.
// - Active transmit-stream bytes go in bits 31:2, in 4-byte units.
// - Active receive-stream bytes are reported in bits 31:2, 4-byte units.
// - Only upstream memory write payload bytes are counted, 4-byte units.
// - Only downstream completion data bytes are counted, 4-byte units.
// - Initial completion data credits sit in a 12-bit field reset to 0.
// - Initial completion header credits sit in an 8-bit field reset to 0.
// - Initial non-posted data credits sit in a 12-bit field reset to 0.
// - Initial non-posted header credits sit in an 8-bit field reset to 0.
// - Initial posted data credits sit in a 12-bit field reset to 0.
// - Byte counts show the last one-second sample, not a running total.
// - Reserved bits and unmapped addresses read as zero.
// - All registers are 32 bits wide and read through BAR0.
`timescale 1ns/1ps
module plm_top #(
  parameter int unsigned SAMPLE_CYCLES = plm_pkg::SAMPLE_CYCLES
) (
  input  wire logic                          REF_CLK,
  input  wire logic                          RESET_N,
  input  wire logic                          TX_TVALID,
  input  wire logic                          TX_TREADY,
  input  wire logic [plm_pkg::KEEP_W-1:0]    TX_TKEEP,
  input  wire logic                          TX_MWR_PAYLOAD,
  input  wire logic                          RX_TVALID,
  input  wire logic                          RX_TREADY,
  input  wire logic [plm_pkg::KEEP_W-1:0]    RX_TKEEP,
  input  wire logic                          RX_CPLD_PAYLOAD,
  input  wire logic                          LINK_UP,
  input  wire logic [plm_pkg::CRD_D_W-1:0]   CPL_DATA_CREDIT_INIT,
  input  wire logic [plm_pkg::CRD_H_W-1:0]   CPL_HEADER_CREDIT_INIT,
  input  wire logic [plm_pkg::CRD_D_W-1:0]   NONPOSTED_DATA_CREDIT_INIT,
  input  wire logic [plm_pkg::CRD_H_W-1:0]   NONPOSTED_HEADER_CREDIT_INIT,
  input  wire logic [plm_pkg::CRD_D_W-1:0]   POSTED_DATA_CREDIT_INIT,
  input  wire logic                          REG_RD_EN,
  input  wire logic [plm_pkg::ADDR_W-1:0]    REG_ADDR,
  output logic                               REG_RD_VALID,
  output logic      [plm_pkg::DATA_W-1:0]    REG_RD_DATA
);
  import plm_pkg::*;

  localparam logic [TIMER_W-1:0] LAST_CYCLE = TIMER_W'(SAMPLE_CYCLES - 1);

  logic [TIMER_W-1:0]  timer_ff;
  logic [TIMER_W-1:0]  nxt_timer;
  logic                tick_ff;
  logic                nxt_tick;
  logic [SCNT_W-1:0]   scnt_ff;
  logic [SCNT_W-1:0]   nxt_scnt;
  plm_cap_t            cap_ff;
  plm_cap_t            nxt_cap;
  logic                cap_now;
  logic [CRD_D_W-1:0]  crd_cd_ff;
  logic [CRD_H_W-1:0]  crd_ch_ff;
  logic [CRD_D_W-1:0]  crd_npd_ff;
  logic [CRD_H_W-1:0]  crd_nph_ff;
  logic [CRD_D_W-1:0]  crd_pd_ff;
  logic                tx_beat;
  logic                rx_beat;
  logic [ACC_W-1:0]    tx_run;
  logic [ACC_W-1:0]    rx_run;
  logic [ACC_W-1:0]    mwr_run;
  logic [ACC_W-1:0]    cpl_run;
  logic [ACC_W-1:0]    tx_snap;
  logic [ACC_W-1:0]    rx_snap;
  logic [ACC_W-1:0]    mwr_snap;
  logic [ACC_W-1:0]    cpl_snap;
  logic [DATA_W-1:0]   tx_word;
  logic [DATA_W-1:0]   rx_word;
  logic [DATA_W-1:0]   mwr_word;
  logic [DATA_W-1:0]   cpl_word;
  logic [DATA_W-1:0]   rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // One-second sample timer and shared sample counter
  assign nxt_timer = (timer_ff == LAST_CYCLE) ? '0 : timer_ff + 1'b1;
  assign nxt_tick  = (timer_ff == LAST_CYCLE);
  assign nxt_scnt  = tick_ff ? scnt_ff + 1'b1 : scnt_ff;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      timer_ff <= '0;
      tick_ff  <= 1'b0;
      scnt_ff  <= '0;
    end else begin
      timer_ff <= nxt_timer;
      tick_ff  <= nxt_tick;
      scnt_ff  <= nxt_scnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Beat qualification: only transferred beats count
  assign tx_beat = TX_TVALID & TX_TREADY;
  assign rx_beat = RX_TVALID & RX_TREADY;

  // Transmit stream bytes
  plm_acc #(.KEEP_W(KEEP_W), .ACC_W(ACC_W)) u_tx_acc (
    .clk     (REF_CLK),
    .rst_n   (RESET_N),
    .beat_ok (tx_beat),
    .keep    (TX_TKEEP),
    .tick    (tick_ff),
    .run_ff  (tx_run),
    .snap_ff (tx_snap)
  );

  // Receive stream bytes
  plm_acc #(.KEEP_W(KEEP_W), .ACC_W(ACC_W)) u_rx_acc (
    .clk     (REF_CLK),
    .rst_n   (RESET_N),
    .beat_ok (rx_beat),
    .keep    (RX_TKEEP),
    .tick    (tick_ff),
    .run_ff  (rx_run),
    .snap_ff (rx_snap)
  );

  // Upstream memory write payload, header beats excluded
  plm_acc #(.KEEP_W(KEEP_W), .ACC_W(ACC_W)) u_mwr_acc (
    .clk     (REF_CLK),
    .rst_n   (RESET_N),
    .beat_ok (tx_beat & TX_MWR_PAYLOAD),
    .keep    (TX_TKEEP),
    .tick    (tick_ff),
    .run_ff  (mwr_run),
    .snap_ff (mwr_snap)
  );

  // Downstream completion data payload
  plm_acc #(.KEEP_W(KEEP_W), .ACC_W(ACC_W)) u_cpl_acc (
    .clk     (REF_CLK),
    .rst_n   (RESET_N),
    .beat_ok (rx_beat & RX_CPLD_PAYLOAD),
    .keep    (RX_TKEEP),
    .tick    (tick_ff),
    .run_ff  (cpl_run),
    .snap_ff (cpl_snap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Initial credit capture, once per reset after link-up
  assign cap_now = (cap_ff == CAP_WAIT) && LINK_UP;

  always_comb begin
    nxt_cap = cap_ff;
    unique case (cap_ff)
      CAP_WAIT: begin
        if (LINK_UP) begin
          nxt_cap = CAP_HELD;
        end
      end
      CAP_HELD: begin
        nxt_cap = CAP_HELD;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cap_ff <= CAP_WAIT;
    end else begin
      cap_ff <= nxt_cap;
    end
  end

  // Credit fields, cleared by reset and loaded once
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      crd_cd_ff  <= '0;
      crd_ch_ff  <= '0;
      crd_npd_ff <= '0;
      crd_nph_ff <= '0;
      crd_pd_ff  <= '0;
    end else if (cap_now) begin
      crd_cd_ff  <= CPL_DATA_CREDIT_INIT;
      crd_ch_ff  <= CPL_HEADER_CREDIT_INIT;
      crd_npd_ff <= NONPOSTED_DATA_CREDIT_INIT;
      crd_nph_ff <= NONPOSTED_HEADER_CREDIT_INIT;
      crd_pd_ff  <= POSTED_DATA_CREDIT_INIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read words: count in 4-byte units above the sample count
  assign tx_word  = {tx_snap[ACC_W-1:CNT_LSB], scnt_ff};
  assign rx_word  = {rx_snap[ACC_W-1:CNT_LSB], scnt_ff};
  assign mwr_word = {mwr_snap[ACC_W-1:CNT_LSB], scnt_ff};
  assign cpl_word = {cpl_snap[ACC_W-1:CNT_LSB], scnt_ff};

  // Address decode; holes and upper credit bits read as zero
  assign rd_word =
    (REG_ADDR == OFS_TX_BYTES)  ? tx_word  :
    (REG_ADDR == OFS_RX_BYTES)  ? rx_word  :
    (REG_ADDR == OFS_MWR_BYTES) ? mwr_word :
    (REG_ADDR == OFS_CPL_BYTES) ? cpl_word :
    (REG_ADDR == OFS_CRD_CD)    ? DATA_W'(crd_cd_ff)  :
    (REG_ADDR == OFS_CRD_CH)    ? DATA_W'(crd_ch_ff)  :
    (REG_ADDR == OFS_CRD_NPD)   ? DATA_W'(crd_npd_ff) :
    (REG_ADDR == OFS_CRD_NPH)   ? DATA_W'(crd_nph_ff) :
    (REG_ADDR == OFS_CRD_PD)    ? DATA_W'(crd_pd_ff)  :
    RST_WORD;

  // Registered read answer, one cycle after the request
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RD_VALID <= 1'b0;
      REG_RD_DATA  <= RST_WORD;
    end else begin
      REG_RD_VALID <= REG_RD_EN;
      if (REG_RD_EN) begin
        REG_RD_DATA <= rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  AST_SCNT_STEP: assert property (tick_ff |=>
      scnt_ff == $past(scnt_ff) + 2'h1)
    else $error("sample count did not advance on boundary");
  AST_SCNT_HOLD: assert property (!tick_ff |=> $stable(scnt_ff))
    else $error("sample count moved between boundaries");
  AST_TX_SNAP: assert property (tick_ff |=>
      tx_snap == $past(tx_run))
    else $error("transmit count not copied at boundary");
  AST_MWR_SNAP: assert property (tick_ff |=>
      mwr_snap == $past(mwr_run))
    else $error("write payload count not copied at boundary");
  AST_CPL_SNAP: assert property (tick_ff |=>
      cpl_snap == $past(cpl_run))
    else $error("completion payload count not copied at boundary");
  AST_TICK_GAP: assert property (tick_ff |=> !tick_ff [*2])
    else $error("sample boundaries too close");
  AST_RD_TX: assert property (REG_RD_EN &&
      REG_ADDR == OFS_TX_BYTES |=> REG_RD_DATA ==
      {$past(tx_snap[ACC_W-1:CNT_LSB]), $past(scnt_ff)})
    else $error("transmit register read wrong");
  AST_RD_RX: assert property (REG_RD_EN &&
      REG_ADDR == OFS_RX_BYTES |=>
      REG_RD_DATA[CNT_LSB-1:0] == $past(scnt_ff))
    else $error("receive register sample count wrong");
  AST_RD_HOLE: assert property (REG_RD_EN && rd_word == RST_WORD
      |=> REG_RD_VALID && REG_RD_DATA == RST_WORD)
    else $error("hole or zero field did not read zero");
  AST_RD_CD: assert property (REG_RD_EN &&
      REG_ADDR == OFS_CRD_CD |=> REG_RD_DATA == DATA_W'($past(crd_cd_ff)))
    else $error("completion data credit read wrong");
  AST_RD_VALID: assert property (REG_RD_EN |=> REG_RD_VALID ##1
      (REG_RD_VALID == $past(REG_RD_EN)))
    else $error("read answer not one cycle after request");
  AST_CAP_LOAD: assert property (cap_now |=> cap_ff == CAP_HELD &&
      crd_cd_ff == $past(CPL_DATA_CREDIT_INIT) &&
      crd_ch_ff == $past(CPL_HEADER_CREDIT_INIT) &&
      crd_npd_ff == $past(NONPOSTED_DATA_CREDIT_INIT) &&
      crd_nph_ff == $past(NONPOSTED_HEADER_CREDIT_INIT) &&
      crd_pd_ff == $past(POSTED_DATA_CREDIT_INIT))
    else $error("credits not captured at link-up");
  AST_CAP_HOLD: assert property (cap_ff == CAP_HELD |=>
      $stable(crd_cd_ff) && $stable(crd_ch_ff) && $stable(crd_npd_ff) &&
      $stable(crd_nph_ff) && $stable(crd_pd_ff))
    else $error("captured credits changed");

  COV_TICK: cover property (tick_ff ##1 tick_ff == 1'b0);
  COV_CAPTURE: cover property (cap_now);
  COV_READ_MWR: cover property (REG_RD_EN && REG_ADDR == OFS_MWR_BYTES
      && mwr_snap != '0);
  COV_BEAT_AT_TICK: cover property (tick_ff && tx_beat);

endmodule
